/* File: hw/touch_aperture_pkg.sv */
// shared constants, tags and carriers of the aperture logger
package touch_aperture_pkg;

   localparam int         POS_W          = 12;
   localparam int         WORD_W         = 16;
   localparam logic [6:0] APR_CFG_ADDR   = 7'h0B;
   localparam logic [7:0] APR_CFG_RESET  = 8'h00;
   // exponent codes above this one disable checking
   localparam logic [3:0] APR_EXP_MAX    = 4'hC;
   localparam int         APR_X_LSB      = 4;
   localparam int         APR_Y_LSB      = 0;
   localparam int         FRAC_LSB       = 0;
   localparam int         FRAC_W         = 4;
   localparam logic [2:0] WORDS_MAX      = 3'h4;

   typedef enum logic [1:0] {
      MEAS_X  = 2'b00,
      MEAS_Y  = 2'b01,
      MEAS_Z1 = 2'b10,
      MEAS_Z2 = 2'b11
   } meas_tag_t;

   typedef enum logic [1:0] {
      EV_INITIAL  = 2'b00,
      EV_MIDPRESS = 2'b01,
      EV_RELEASE  = 2'b10,
      EV_EOF      = 2'b11
   } event_tag_t;

   typedef enum logic [1:0] {
      SCAN_XY     = 2'b00,
      SCAN_XYZ1   = 2'b01,
      SCAN_XYZ1Z2 = 2'b10
   } scan_type_t;

   typedef struct packed {
      scan_type_t         kind;
      logic [POS_W-1:0]   x;
      logic [POS_W-1:0]   y;
      logic [POS_W-1:0]   z1;
      logic [POS_W-1:0]   z2;
      logic               touchAtEnd;
      logic               touchSeen;
      logic               conv8Bit;
      logic               averaging;
   } scan_block_t;

   typedef struct packed {
      logic [POS_W-1:0] pos;
      meas_tag_t        meas;
      event_tag_t       evTag;
   } fifo_word_t;

   localparam fifo_word_t EOF_WORD = '{pos: 12'h000, meas: MEAS_X,
                                       evTag: EV_EOF};

endpackage : touch_aperture_pkg

/* File: hw/aperture_check.sv */
// one-axis aperture test: distance from reference against 2^(n-1)
`timescale 1ns/1ps
module aperture_check (
   input  wire logic [3:0]  rangeExponent,
   input  wire logic [11:0] position,
   input  wire logic [11:0] reference,
   output logic             checkEnabled,
   output logic             meetsRange
);
   logic [12:0] range;
   logic [11:0] distance;

   always_comb begin
      // codes 0 and 13..15 switch the axis off
      checkEnabled = (rangeExponent != 4'h0) && // see RULE_03 RULE_05
                     (rangeExponent <= touch_aperture_pkg::APR_EXP_MAX);
      range = checkEnabled ? (13'h0001 << (rangeExponent - 4'h1))
                           : 13'h1FFF; // see RULE_04
      distance = (position >= reference) ? position - reference
                                         : reference - position; // see RULE_02
      meetsRange = checkEnabled && ({1'b0, distance} >= range); // see RULE_12
   end
endmodule : aperture_check

/* File: hw/word_skid_buffer.sv */
// two-entry buffer between word emitter and result storage
`timescale 1ns/1ps
module word_skid_buffer (
   input  wire logic                          clk_sys,
   input  wire logic                          reset_n,
   input  wire logic                          inValid,
   input  wire touch_aperture_pkg::fifo_word_t inData,
   output logic                               inReady,
   output logic                               outValid,
   output touch_aperture_pkg::fifo_word_t      outData,
   input  wire logic                          outReady
);
   typedef struct packed {
      touch_aperture_pkg::fifo_word_t head;
      touch_aperture_pkg::fifo_word_t tail;
      logic [1:0]                     count;
   } buf_state_t;

   buf_state_t s_reg;
   buf_state_t s_next;
   logic       pop;
   logic       push;

   always_comb begin
      s_next = s_reg;
      pop    = (s_reg.count != 2'd0) && outReady;
      push   = inValid && (s_reg.count != 2'd2);
      if (pop) begin
         s_next.head = s_reg.tail;
      end
      if (push) begin
         if (s_reg.count == 2'd0 || (s_reg.count == 2'd1 && pop)) begin
            s_next.head = inData;
         end else begin
            s_next.tail = inData;
         end
      end
      s_next.count = s_reg.count + 2'(push) - 2'(pop);
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ready does not look at outReady, so no combinational path through
   assign inReady  = (s_reg.count != 2'd2);
   assign outValid = (s_reg.count != 2'd0);
   assign outData  = s_reg.head;
endmodule : word_skid_buffer

/* File: hw/touch_aperture_fifo_logger.sv */
// aperture filter, event tagging and touch interrupt of the result log
`timescale 1ns/1ps

// Overview of operation
// RULE_01: X and Y aperture ranges both come from configuration register 0x0B.
// RULE_02: blanking box: plus/minus range around reference, 12-bit positions.
// RULE_03: all-zero aperture setting disables checking; all results logged.
// RULE_04: exponent n from 1 to 12 gives range of 2^(n-1) LSBs.
// RULE_05: exponents 13, 14 and 15 disable checking like zero.
// RULE_06: word bits 3:2 tag measurement: X 00, Y 01, Z1 10, Z2 11.
// RULE_07: word bits 1:0 tag event: initial, midpress, release, end of file.
// RULE_08: 8-bit results without averaging get zero fraction bits.
// RULE_09: aperture filtering only in autonomous mode, never in direct mode.
// RULE_10: new touch always logs a 00-tagged block and raises the interrupt.
// RULE_11: touch end always logs a 10-tagged block and raises the interrupt.
// RULE_12: midpress logs 01 when X or Y change reaches its range.
// RULE_13: each logged block raises interrupt, held until all data read back; code also clears it on a 0x0B write or a mode change.
// RULE_14: scanning continues after a log; each new result gets tested.
// RULE_15: touch too brief for both entries logs only a release entry.
// RULE_16: every complete touch yields an initial entry and a release entry.
// RULE_17: host treats release positions as invalid and times presses itself.
// RULE_18: host services interrupts fast enough to avoid storage overflow.
// RULE_19: position sits in word bits 15:4, most significant byte first.
// RULE_20: all words of one block share the tag from end-of-block status.
// RULE_21: readback with no unread data returns words tagged 11.
// RULE_22: each logged midpress position becomes the new reference point.
module touch_aperture_fifo_logger (
   input  wire logic                          clk_sys,
   input  wire logic                          reset_n,
   input  wire logic                          autonomousMode,
   input  wire logic                          regWrite,
   input  wire logic [6:0]                    regAddr,
   input  wire logic [7:0]                    regWrData,
   output logic [7:0]                         regRdData,
   input  wire logic                          scanValid,
   input  wire touch_aperture_pkg::scan_block_t scanBlock,
   output logic                               scanReady,
   output logic                               wordValid,
   output touch_aperture_pkg::fifo_word_t      wordData,
   input  wire logic                          wordReady,
   input  wire logic                          logAllRead,
   input  wire touch_aperture_pkg::fifo_word_t logRdData,
   output touch_aperture_pkg::fifo_word_t      readWord,
   output logic                               touch_interrupt_out
);
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_EMIT = 1'b1
   } log_state_t;

   typedef struct packed {
      log_state_t                     state;
      logic [7:0]                     aperture_range_config;
      logic                           touchActive;
      logic [11:0]                    refX;
      logic [11:0]                    refY;
      touch_aperture_pkg::scan_block_t block;
      touch_aperture_pkg::event_tag_t blockTag;
      logic [2:0]                     wordIdx;
      logic                           scanReady;
      logic                           irq;
      logic                           modePrev;
      logic [7:0]                     rdData;
      touch_aperture_pkg::fifo_word_t readWord;
      logic                           bufOutValid;
      touch_aperture_pkg::fifo_word_t bufOutData;
   } logger_state_t;

   logger_state_t                  s_reg;
   logger_state_t                  s_next;
   logic [3:0]                     x_range_exponent;
   logic [3:0]                     y_range_exponent;
   logic                           xEnabled;
   logic                           yEnabled;
   logic                           xMeets;
   logic                           yMeets;
   logic                           bufInValid;
   logic                           bufInReady;
   logic                           bufOutValid;
   logic                           bufOutReady;
   touch_aperture_pkg::fifo_word_t bufInData;
   touch_aperture_pkg::fifo_word_t bufOutData;
   logic [2:0]                     wordsInBlock;
   logic                           lastWord;
   logic                           logIt;
   logic                           irqSet;
   logic                           irqClear;
   logic                           modeChange;
   logic                           cfgWrite;
   touch_aperture_pkg::event_tag_t newTag;

   always_comb begin
      x_range_exponent = s_reg.aperture_range_config[
         touch_aperture_pkg::APR_X_LSB +: 4]; // see RULE_01
      y_range_exponent = s_reg.aperture_range_config[
         touch_aperture_pkg::APR_Y_LSB +: 4]; // see RULE_01
   end

   aperture_check xCheck (
      .rangeExponent (x_range_exponent),
      .position      (scanBlock.x),
      .reference     (s_reg.refX),
      .checkEnabled  (xEnabled),
      .meetsRange    (xMeets)
   );

   aperture_check yCheck (
      .rangeExponent (y_range_exponent),
      .position      (scanBlock.y),
      .reference     (s_reg.refY),
      .checkEnabled  (yEnabled),
      .meetsRange    (yMeets)
   );

   word_skid_buffer wordBuffer (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .inValid  (bufInValid),
      .inData   (bufInData),
      .inReady  (bufInReady),
      .outValid (bufOutValid),
      .outData  (bufOutData),
      .outReady (bufOutReady)
   );

   // word count of the latched block
   always_comb begin
      case (s_reg.block.kind)
         touch_aperture_pkg::SCAN_XY:     wordsInBlock = 3'h2;
         touch_aperture_pkg::SCAN_XYZ1:   wordsInBlock = 3'h3;
         touch_aperture_pkg::SCAN_XYZ1Z2: wordsInBlock = 3'h4;
         default:                         wordsInBlock = 3'h2;
      endcase
   end

   // word assembly: position high, then measure and event tags
   always_comb begin
      bufInData.evTag = s_reg.blockTag; // see RULE_07 RULE_20
      case (s_reg.wordIdx[1:0])
         2'd0: begin
            bufInData.pos  = s_reg.block.x;
            bufInData.meas = touch_aperture_pkg::MEAS_X; // see RULE_06
         end
         2'd1: begin
            bufInData.pos  = s_reg.block.y;
            bufInData.meas = touch_aperture_pkg::MEAS_Y; // see RULE_06
         end
         2'd2: begin
            bufInData.pos  = s_reg.block.z1;
            bufInData.meas = touch_aperture_pkg::MEAS_Z1; // see RULE_06
         end
         default: begin
            bufInData.pos  = s_reg.block.z2;
            bufInData.meas = touch_aperture_pkg::MEAS_Z2; // see RULE_06
         end
      endcase
      // a 3-word block needs no index skip: its third word is Z1 anyway
      if (s_reg.block.conv8Bit && !s_reg.block.averaging) begin
         bufInData.pos[touch_aperture_pkg::FRAC_LSB +:
                       touch_aperture_pkg::FRAC_W] = 4'h0; // see RULE_08
      end
   end

   // tagging and aperture decision on the incoming block
   always_comb begin
      logIt  = 1'b0;
      newTag = touch_aperture_pkg::EV_MIDPRESS;
      if (scanBlock.touchAtEnd && !s_reg.touchActive) begin
         logIt  = 1'b1;
         newTag = touch_aperture_pkg::EV_INITIAL; // see RULE_10 RULE_16
      end else if (scanBlock.touchAtEnd) begin
         // direct mode or both axes off: nothing is filtered
         if (!autonomousMode || (!xEnabled && !yEnabled)) begin
            logIt = 1'b1; // see RULE_03 RULE_05 RULE_09
         end else begin
            logIt = xMeets || yMeets; // see RULE_12 RULE_14
         end
         newTag = touch_aperture_pkg::EV_MIDPRESS;
      end else if (s_reg.touchActive) begin
         logIt  = 1'b1;
         newTag = touch_aperture_pkg::EV_RELEASE; // see RULE_11 RULE_16
      end else if (scanBlock.touchSeen) begin
         // glitch touch: seen during the scan but gone at its end
         logIt  = 1'b1;
         newTag = touch_aperture_pkg::EV_RELEASE; // see RULE_15
      end
   end

   always_comb begin
      s_next      = s_reg;
      bufInValid  = 1'b0;
      irqSet      = 1'b0;
      lastWord    = (s_reg.wordIdx == wordsInBlock - 3'h1);
      cfgWrite    = regWrite && (regAddr == touch_aperture_pkg::APR_CFG_ADDR);
      modeChange  = (autonomousMode != s_reg.modePrev);
      bufOutReady = !s_reg.bufOutValid || wordReady;

      s_next.modePrev = autonomousMode;
      if (cfgWrite) begin
         s_next.aperture_range_config = regWrData; // see RULE_01
      end
      s_next.rdData = (regAddr == touch_aperture_pkg::APR_CFG_ADDR)
                      ? s_reg.aperture_range_config : 8'h00;

      case (s_reg.state)
         ST_IDLE: begin
            s_next.scanReady = 1'b1;
            if (scanValid && s_reg.scanReady) begin
               s_next.touchActive = scanBlock.touchAtEnd;
               if (logIt) begin
                  s_next.block     = scanBlock;
                  s_next.blockTag  = newTag; // see RULE_20
                  s_next.wordIdx   = 3'h0;
                  s_next.state     = ST_EMIT;
                  s_next.scanReady = 1'b0;
                  if (scanBlock.touchAtEnd) begin
                     s_next.refX = scanBlock.x; // see RULE_22
                     s_next.refY = scanBlock.y; // see RULE_22
                  end
               end
            end
         end
         ST_EMIT: begin
            s_next.scanReady = 1'b0;
            bufInValid = 1'b1;
            if (bufInReady) begin
               s_next.wordIdx = s_reg.wordIdx + 3'h1;
               if (lastWord) begin
                  // interrupt only once the whole block is queued
                  irqSet           = 1'b1; // see RULE_13
                  s_next.state     = ST_IDLE;
                  s_next.scanReady = 1'b1;
               end
            end
         end
         default: begin
            s_next.state     = ST_IDLE;
            s_next.scanReady = 1'b0;
         end
      endcase

      // a mode change restarts touch tracking from scratch
      if (modeChange) begin
         s_next.touchActive = 1'b0;
      end

      // output stage: hold word until storage accepts it
      if (bufOutReady) begin
         s_next.bufOutValid = bufOutValid;
         s_next.bufOutData  = bufOutData;
      end

      irqClear = (logAllRead && s_reg.state == ST_IDLE &&
                  !s_reg.bufOutValid && !bufOutValid) ||
                 cfgWrite || modeChange;
      // a new block in the clearing cycle keeps the interrupt up
      s_next.irq = (s_reg.irq && !irqClear) || irqSet; // see RULE_13

      s_next.readWord = logAllRead ? touch_aperture_pkg::EOF_WORD
                                   : logRdData; // see RULE_21 RULE_19
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_reg                       <= '0;
         s_reg.state                 <= ST_IDLE;
         s_reg.aperture_range_config <= touch_aperture_pkg::APR_CFG_RESET;
         s_reg.readWord              <= touch_aperture_pkg::EOF_WORD;
      end else begin
         s_reg <= s_next;
      end
   end

   assign regRdData           = s_reg.rdData;
   assign scanReady           = s_reg.scanReady;
   assign wordValid           = s_reg.bufOutValid;
   assign wordData            = s_reg.bufOutData;
   assign readWord            = s_reg.readWord;
   assign touch_interrupt_out = s_reg.irq;
endmodule : touch_aperture_fifo_logger

/* File: verif/touch_aperture_fifo_logger_props.sv */
// port assertions of the aperture logger
`timescale 1ns/1ps
module touch_aperture_fifo_logger_props (
   input wire logic                           clk_sys,
   input wire logic                           reset_n,
   input wire logic                           autonomousMode,
   input wire logic                           regWrite,
   input wire logic [6:0]                     regAddr,
   input wire logic [7:0]                     regWrData,
   input wire logic [7:0]                     regRdData,
   input wire logic                           wordValid,
   input wire touch_aperture_pkg::fifo_word_t wordData,
   input wire logic                           wordReady,
   input wire logic                           logAllRead,
   input wire touch_aperture_pkg::fifo_word_t readWord,
   input wire logic                           touch_interrupt_out
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   property p_cfg_read;
      regWrite && regAddr == 7'h0B ##1 !regWrite && regAddr == 7'h0B
      |=> regRdData == $past(regWrData, 2);
   endproperty
   a_cfg_read: assert property (p_cfg_read)
      else $error("config readback differs from write");
   property p_unmapped;
      regAddr != 7'h0B |=> regRdData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped address reads nonzero");
   property p_eof;
      logAllRead |=> readWord == touch_aperture_pkg::EOF_WORD;
   endproperty
   a_eof: assert property (p_eof)
      else $error("empty log not read as end marker");
   property p_irq_hold;
      touch_interrupt_out && !logAllRead && !regWrite
      && $stable(autonomousMode) |=> touch_interrupt_out;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt dropped with unread data");
   property p_irq_word;
      wordValid && wordReady |-> ##[0:6] touch_interrupt_out;
   endproperty
   a_irq_word: assert property (p_irq_word)
      else $error("logged word without interrupt");
   property p_no_eof_tag;
      wordValid |-> wordData[1:0] != 2'h3;
   endproperty
   a_no_eof_tag: assert property (p_no_eof_tag)
      else $error("end marker tag written to log");
   property p_stall;
      wordValid && !wordReady |=> wordValid && $stable(wordData);
   endproperty
   a_stall: assert property (p_stall)
      else $error("stalled word lost or changed");
   property p_order;
      wordValid && wordReady && wordData[3:2] == 2'h0
      |=> !wordValid || wordData[3:2] == 2'h1;
   endproperty
   a_order: assert property (p_order)
      else $error("second word of block not Y");
endmodule : touch_aperture_fifo_logger_props

bind touch_aperture_fifo_logger touch_aperture_fifo_logger_props u_props (
   .clk_sys, .reset_n, .autonomousMode, .regWrite, .regAddr, .regWrData,
   .regRdData, .wordValid, .wordData, .wordReady, .logAllRead, .readWord,
   .touch_interrupt_out
);

/* File: verif/result_log_model.sv */
// result storage and host reader behind the logger
`timescale 1ns/1ps
module result_log_model (
   input  wire logic                           clk_sys,
   input  wire logic                           reset_n,
   input  wire logic                           wordValid,
   input  wire touch_aperture_pkg::fifo_word_t wordData,
   output logic                                wordReady,
   input  wire logic                           stallReq,
   input  wire logic                           popReq,
   output logic                                logAllRead,
   output touch_aperture_pkg::fifo_word_t      logRdData
);
   touch_aperture_pkg::fifo_word_t store[$];
   touch_aperture_pkg::fifo_word_t lastWord = '0;

   assign wordReady = !stallReq;
   // empty store shows inverted last word so stale data never looks fresh
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         store.delete();
      end else begin
         if (popReq && store.size() > 0) begin
            lastWord = store.pop_front();
         end
         if (wordValid && wordReady) begin
            store.push_back(wordData);
         end
      end
      logAllRead <= (store.size() == 0);
      logRdData  <= (store.size() == 0) ? ~lastWord : store[0];
   end
endmodule : result_log_model

/* File: verif/touch_aperture_fifo_logger_tb_top.sv */
// testbench of the aperture logger against a storage model
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin \
   $display("mismatch %s expected %h seen %h", nm, ex, got); \
   mismatches++; end end
module touch_aperture_fifo_logger_tb_top;
   logic                              clk_sys = 1'h0;
   logic                              reset_n = 1'h0;
   logic                              autonomousMode = 1'h1;
   logic                              regWrite = 1'h0;
   logic [6:0]                        regAddr = 7'h00;
   logic [7:0]                        regWrData = 8'h00;
   logic [7:0]                        regRdData;
   logic                              scanValid = 1'h0;
   touch_aperture_pkg::scan_block_t   scanBlock = '0;
   logic                              scanReady, wordValid, wordReady;
   touch_aperture_pkg::fifo_word_t    wordData, logRdData, readWord;
   logic                              logAllRead, touch_interrupt_out;
   logic                              stallReq = 1'h0;
   logic                              popReq = 1'h0;
   touch_aperture_pkg::fifo_word_t    expQ[$];
   int                                mismatches = 0;
   int                                cmpCount = 0;

   touch_aperture_fifo_logger dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .autonomousMode(autonomousMode), .regWrite(regWrite),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .scanValid(scanValid), .scanBlock(scanBlock), .scanReady(scanReady),
      .wordValid(wordValid), .wordData(wordData), .wordReady(wordReady),
      .logAllRead(logAllRead), .logRdData(logRdData), .readWord(readWord),
      .touch_interrupt_out(touch_interrupt_out));
   result_log_model logModel (.clk_sys(clk_sys), .reset_n(reset_n),
      .wordValid(wordValid), .wordData(wordData), .wordReady(wordReady),
      .stallReq(stallReq), .popReq(popReq), .logAllRead(logAllRead),
      .logRdData(logRdData));

   initial begin
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
      if (mismatches == 0 && cmpCount > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   task automatic regWr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      regWrite = 1'h1;
      regAddr = a;
      regWrData = d;
      @(negedge clk_sys);
      regWrite = 1'h0;
   endtask : regWr

   task automatic regRd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      regAddr = a;
      @(negedge clk_sys);
      d = regRdData;
   endtask : regRd

   // offer one block and hold it until the logger takes it
   task automatic scan(input touch_aperture_pkg::scan_type_t k,
                       input logic [11:0] x, y, input logic t, c8,
                       input logic av = 1'h0);
      int n = 0;
      @(negedge clk_sys);
      scanBlock = {k, x, y, 12'h5A5, 12'h3C3, t, 1'h1, c8, av};
      scanValid = 1'h1;
      while (scanReady !== 1'h1 && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("scan ready", 1'h1, scanReady)
      @(negedge clk_sys);
      scanValid = 1'h0;
   endtask : scan

   task automatic step(input logic [11:0] x, y, input logic t, lg,
                       input logic [1:0] ev);
      scan(touch_aperture_pkg::SCAN_XY, x, y, t, 1'h0);
      if (lg) begin
         expQ.push_back({x, 2'h0, ev});
         expQ.push_back({y, 2'h1, ev});
      end
   endtask : step

   // host reads the log word by word, one per expected word, then checks the end marker
   task automatic drain();
      touch_aperture_pkg::fifo_word_t e;
      int n;
      repeat (12) @(negedge clk_sys);
      `CHK("irq", expQ.size() > 0, touch_interrupt_out)
      while (expQ.size() > 0) begin
         e = expQ.pop_front();
         n = 0;
         while (logAllRead !== 1'h0 && n < 100) begin
            @(negedge clk_sys);
            n++;
         end
         repeat (2) @(negedge clk_sys);
         `CHK("word", e, readWord)
         popReq = 1'h1;
         @(negedge clk_sys);
         popReq = 1'h0;
      end
      repeat (3) @(negedge clk_sys);
      `CHK("eof", touch_aperture_pkg::EOF_WORD, readWord)
      `CHK("irq clear", 1'h0, touch_interrupt_out)
   endtask : drain

   task automatic checkRegs();
      logic [7:0] d;
      regRd(7'h0B, d);
      `CHK("cfg reset", touch_aperture_pkg::APR_CFG_RESET, d)
      regWr(7'h0C, 8'h5A);
      regRd(7'h0C, d);
      `CHK("unmapped", 8'h00, d)
      regWr(7'h0B, 8'h33);
      regRd(7'h0B, d);
      `CHK("cfg", 8'h33, d)
   endtask : checkRegs

   // ranges of 4 on both axes, boundary moves on each axis
   task automatic checkAperture();
      step(12'h100, 12'h100, 1'h1, 1'h1, 2'h0);
      step(12'h103, 12'h0FD, 1'h1, 1'h0, 2'h1);
      step(12'h104, 12'h103, 1'h1, 1'h1, 2'h1);
      step(12'h104, 12'h0FF, 1'h1, 1'h1, 2'h1);
      step(12'h100, 12'h0FF, 1'h1, 1'h1, 2'h1);
      step(12'h100, 12'h0FF, 1'h0, 1'h1, 2'h2);
      drain();
   endtask : checkAperture

   task automatic checkCodes();
      logic [3:0]  codes[6] = '{4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF};
      logic [11:0] r;
      foreach (codes[i]) begin
         regWr(7'h0B, {codes[i], codes[i]});
         r = (codes[i] == 4'h0 || codes[i] > 4'hC) ? 12'h000
             : 12'h001 << (codes[i] - 4'h1);
         step(12'h000, 12'h000, 1'h1, 1'h1, 2'h0);
         step((r == 12'h000) ? r : r - 12'h001, 12'h000, 1'h1,
              r == 12'h000, 2'h1);
         step(r, 12'h000, 1'h1, 1'h1, 2'h1);
         step(r, 12'h000, 1'h0, 1'h1, 2'h2);
         drain();
      end
   endtask : checkCodes

   // brief 8-bit touch of four words while storage stalls
   task automatic checkGlitch();
      stallReq = 1'h1;
      scan(touch_aperture_pkg::SCAN_XYZ1Z2, 12'hABC, 12'h123, 1'h0, 1'h1);
      repeat (10) @(negedge clk_sys);
      `CHK("stall valid", 1'h1, wordValid)
      `CHK("stall ready", 1'h0, scanReady)
      stallReq = 1'h0;
      expQ = '{16'hAB02, 16'h1206, 16'h5A0A, 16'h3C0E};
      drain();
   endtask : checkGlitch

   task automatic checkDirect();
      regWr(7'h0B, 8'h88);
      @(negedge clk_sys);
      autonomousMode = 1'h0;
      step(12'h200, 12'h200, 1'h1, 1'h1, 2'h0);
      step(12'h200, 12'h200, 1'h1, 1'h1, 2'h1);
      step(12'h200, 12'h200, 1'h0, 1'h1, 2'h2);
      // averaged 8-bit glitch keeps its fraction bits
      scan(touch_aperture_pkg::SCAN_XYZ1, 12'hABC, 12'h123, 1'h0, 1'h1,
           1'h1);
      expQ.push_back(16'hABC2);
      expQ.push_back(16'h1236);
      expQ.push_back(16'h5A5A);
      drain();
   endtask : checkDirect

   initial begin
      repeat (10) @(posedge clk_sys);
      @(negedge clk_sys);
      reset_n = 1'h1;
      repeat (2) @(negedge clk_sys);
      checkRegs();
      checkAperture();
      checkCodes();
      checkGlitch();
      checkDirect();
      summarize();
   end

   // run needs about 500 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      summarize();
   end
endmodule : touch_aperture_fifo_logger_tb_top
